// >>> hw/spi_fram_write_protect_control.v
// SPI slave command decoder and write-protection control for a serial F-RAM.
// Assumes SPI mode 0 or 3 pins from outside, sampled on core_clk (40 MHz, sck 5 MHz),
// and a wake sequencer elsewhere that raises wake_busy.
//
// Overview of operation
// - Reset clears the write enable latch.
// - Opcode 06h sets the latch; status bit 1 mirrors it.
// - Status, array, special-sector and serial-number writes need the latch set.
// - Chip-select rise after any write-class or 04h operation clears the latch.
// - Opcode 04h clears the latch.
// - Status writes ignore data in the latch bit position.
// - Status bit 7 pin enable, bit 3/2 block protect, bit 1 latch.
// - Bits 4,5 read zero, bit 6 reads one, bit 0 reads wake_busy, none writable.
// - Bit 0 is set only while waking from deep sleep or hibernate.
// - Block-protect bits are kept across power cycles.
// - Codes 00 none, 01 upper quarter, 10 upper half, 11 all protected.
// - Pin enable high with pin low blocks status writes.
// - Array writes gated only by latch and block-protect bits.
// - Fifteen opcodes decoded; others trigger nothing.
// - 03h is an array read, 0Bh a fast array read.
// - Unknown opcode: ignore input and keep output off until next frame.
// - First byte of each frame is the only opcode.
// - Permitted status write loads pin enable and both block-protect bits.
// - Status read returns the status byte on the serial output.
`timescale 1ns/1ps
`default_nettype none
`include "fram_protect_map.vh"

module spi_fram_write_protect_control (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output reg         so,
  output reg         so_oe,
  input  wire        wp_n,
  input  wire        wake_busy,
  input  wire [1:0]  nv_block_protect,
  output reg  [1:0]  nv_block_protect_wr,
  output reg         nv_block_protect_we,
  input  wire [18:0] write_addr,
  output wire        array_write_allowed,
  output reg         read_cmd,
  output reg         fast_read_cmd,
  output reg         array_write_cmd,
  output reg         write_latch_flag
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_OPCODE = 3'd1;
  localparam ST_SRDATA = 3'd2;
  localparam ST_SROUT  = 3'd3;
  localparam ST_PASS   = 3'd4;
  localparam ST_IGNORE = 3'd5;

  reg [2:0] cs_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [1:0] si_sync_reg;
  reg [1:0] wp_sync_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] out_reg;
  reg       protect_pin_enable;
  reg [1:0] block_protect_reg;
  reg       bp_loaded_reg;
  reg       latch_clear_pend_reg;
  reg       sr_write_pend_reg;
  reg [7:0] sr_data_reg;

  wire frame_start = cs_sync_reg[2] & ~cs_sync_reg[1];
  wire frame_end   = ~cs_sync_reg[2] & cs_sync_reg[1];
  wire sck_rise    = ~sck_sync_reg[2] & sck_sync_reg[1] & ~cs_sync_reg[1];
  wire sck_fall    = sck_sync_reg[2] & ~sck_sync_reg[1] & ~cs_sync_reg[1];
  wire [7:0] byte_in = {shift_reg[6:0], si_sync_reg[1]};
  wire sr_locked   = protect_pin_enable & ~wp_sync_reg[1];

  wire [7:0] status_word = {protect_pin_enable, 1'b1, 2'b00,
                            block_protect_reg, write_latch_flag, wake_busy};

  // Decoded opcode classes
  function is_known;
    input [7:0] op;
    begin
      case (op)
        `OP_LATCH_SET, `OP_LATCH_RESET, `OP_STATUS_READ, `OP_STATUS_WRITE,
        `OP_ARRAY_WRITE, `OP_ARRAY_READ, `OP_FAST_ARRAY_READ, `OP_SS_WRITE,
        `OP_SS_READ, `OP_ID_READ, `OP_UID_READ, `OP_SN_WRITE, `OP_SN_READ,
        `OP_DEEP_SLEEP, `OP_HIBERNATE: is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = (op == `OP_STATUS_WRITE) | (op == `OP_ARRAY_WRITE) |
                    (op == `OP_SS_WRITE) | (op == `OP_SN_WRITE);
    end
  endfunction

  // Block protection range check
  function in_protected;
    input [1:0]  bp;
    input [18:0] addr;
    begin
      case (bp)
        2'b00:   in_protected = 1'b0;
        2'b01:   in_protected = (addr >= `QUARTER_BASE) && (addr <= `ARRAY_TOP);
        2'b10:   in_protected = (addr >= `HALF_BASE) && (addr <= `ARRAY_TOP);
        default: in_protected = 1'b1;
      endcase
    end
  endfunction

  assign array_write_allowed = array_write_cmd & write_latch_flag &
                               ~in_protected(block_protect_reg, write_addr);

  always @(posedge core_clk) begin
    if (!nrst) begin
      cs_sync_reg  <= 3'b111;
      sck_sync_reg <= 3'b000;
      si_sync_reg  <= 2'b00;
      wp_sync_reg  <= 2'b11;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[1:0], cs_n};
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      si_sync_reg  <= {si_sync_reg[0], si};
      wp_sync_reg  <= {wp_sync_reg[0], wp_n};
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      state_reg            <= ST_IDLE;
      bit_cnt_reg          <= 3'd0;
      shift_reg            <= 8'h00;
      out_reg              <= 8'h00;
      so                   <= 1'b0;
      so_oe                <= 1'b0;
      write_latch_flag     <= 1'b0;
      protect_pin_enable   <= `PIN_EN_RESET;
      block_protect_reg    <= `BP_RESET;
      bp_loaded_reg        <= 1'b0;
      latch_clear_pend_reg <= 1'b0;
      sr_write_pend_reg    <= 1'b0;
      sr_data_reg          <= 8'h00;
      nv_block_protect_wr  <= 2'b00;
      nv_block_protect_we  <= 1'b0;
      read_cmd             <= 1'b0;
      fast_read_cmd        <= 1'b0;
      array_write_cmd      <= 1'b0;
    end else begin
      nv_block_protect_we <= 1'b0;
      if (!bp_loaded_reg) begin
        block_protect_reg <= nv_block_protect;
        bp_loaded_reg     <= 1'b1;
      end
      if (frame_start) begin
        state_reg   <= ST_OPCODE;
        bit_cnt_reg <= 3'd0;
      end else if (frame_end) begin
        state_reg       <= ST_IDLE;
        so_oe           <= 1'b0;
        read_cmd        <= 1'b0;
        fast_read_cmd   <= 1'b0;
        array_write_cmd <= 1'b0;
        if (latch_clear_pend_reg) begin
          write_latch_flag <= 1'b0;
        end
        if (sr_write_pend_reg) begin
          protect_pin_enable  <= sr_data_reg[`SR_PIN_EN_BIT];
          block_protect_reg   <= {sr_data_reg[`SR_BP_HI_BIT], sr_data_reg[`SR_BP_LO_BIT]};
          nv_block_protect_wr <= {sr_data_reg[`SR_BP_HI_BIT], sr_data_reg[`SR_BP_LO_BIT]};
          nv_block_protect_we <= 1'b1;
        end
        latch_clear_pend_reg <= 1'b0;
        sr_write_pend_reg    <= 1'b0;
      end else if (sck_rise) begin
        shift_reg   <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        if (bit_cnt_reg == 3'd7) begin
          case (state_reg)
            ST_OPCODE: begin
              if (!is_known(byte_in)) begin
                state_reg <= ST_IGNORE;
              end else if (is_write_op(byte_in) && !write_latch_flag) begin
                state_reg <= ST_PASS;
              end else begin
                state_reg <= ST_PASS;
                if (byte_in == `OP_LATCH_SET) begin
                  write_latch_flag <= 1'b1;
                end
                if (byte_in == `OP_LATCH_RESET) begin
                  write_latch_flag <= 1'b0;
                  latch_clear_pend_reg <= 1'b1;
                end
                if (is_write_op(byte_in)) begin
                  latch_clear_pend_reg <= 1'b1;
                end
                if (byte_in == `OP_STATUS_WRITE) begin
                  state_reg <= ST_SRDATA;
                end
                if (byte_in == `OP_STATUS_READ) begin
                  state_reg <= ST_SROUT;
                  out_reg   <= status_word;
                end
                read_cmd        <= (byte_in == `OP_ARRAY_READ);
                fast_read_cmd   <= (byte_in == `OP_FAST_ARRAY_READ);
                array_write_cmd <= (byte_in == `OP_ARRAY_WRITE);
              end
            end
            ST_SRDATA: begin
              if (!sr_locked) begin
                sr_write_pend_reg <= 1'b1;
                sr_data_reg       <= byte_in;
              end
              state_reg <= ST_PASS;
            end
            ST_SROUT: begin
              out_reg <= status_word;
            end
            default: begin
            end
          endcase
        end
      end else if (sck_fall && state_reg == ST_SROUT) begin
        so      <= out_reg[3'd7 - bit_cnt_reg];
        so_oe   <= 1'b1;
      end
    end
  end

endmodule // spi_fram_write_protect_control

`default_nettype wire

// >>> include/fram_protect_map.vh
// Opcodes, status register layout and protection ranges of the SPI write-protect controller.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef FRAM_PROTECT_MAP_VH
`define FRAM_PROTECT_MAP_VH

`define OP_LATCH_SET        8'h06
`define OP_LATCH_RESET      8'h04
`define OP_STATUS_READ      8'h05
`define OP_STATUS_WRITE     8'h01
`define OP_ARRAY_WRITE      8'h02
`define OP_ARRAY_READ       8'h03
`define OP_FAST_ARRAY_READ  8'h0B
`define OP_SS_WRITE         8'h42
`define OP_SS_READ          8'h4B
`define OP_ID_READ          8'h9F
`define OP_UID_READ         8'h4C
`define OP_SN_WRITE         8'hC2
`define OP_SN_READ          8'hC3
`define OP_DEEP_SLEEP       8'hBA
`define OP_HIBERNATE        8'hB9

`define SR_PIN_EN_BIT       7
`define SR_FIXED_ONE_BIT    6
`define SR_BP_HI_BIT        3
`define SR_BP_LO_BIT        2
`define SR_LATCH_BIT        1
`define SR_BUSY_BIT         0

`define BP_RESET            2'b00
`define PIN_EN_RESET        1'b0

`define QUARTER_BASE        19'h6_0000
`define HALF_BASE           19'h4_0000
`define ARRAY_TOP           19'h7_FFFF

`endif

// >>> tb/spi_fram_props.sv
// Checker for the SPI write-protect controller, bound to its top module.
// Assumes pins sampled on core_clk with synchronous active-low nrst.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe,
  input wire logic nv_block_protect_we,
  input wire logic array_write_allowed,
  input wire logic array_write_cmd,
  input wire logic read_cmd,
  input wire logic fast_read_cmd,
  input wire logic write_latch_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence cs_idle; cs_n [*8]; endsequence
  AST_RESET_LATCH: assert property ($rose(nrst) |-> !write_latch_flag)
    else $error("latch set after reset");
  AST_NV_PULSE: assert property (nv_block_protect_we |=> !nv_block_protect_we)
    else $error("store pulse too long");
  AST_NV_LATCH: assert property (nv_block_protect_we |-> $past(write_latch_flag) && !write_latch_flag)
    else $error("status stored without latch or latch kept");
  AST_NV_CS: assert property (nv_block_protect_we |-> cs_n)
    else $error("status stored inside frame");
  AST_ARRAY_GATE: assert property (array_write_allowed |-> array_write_cmd && write_latch_flag)
    else $error("array write allowed without latch");
  AST_SO_IDLE: assert property (cs_idle |-> !so_oe)
    else $error("output driven while deselected");
  AST_CMD_IDLE: assert property (cs_idle |-> !(read_cmd || fast_read_cmd || array_write_cmd))
    else $error("command kept after frame");
  AST_LATCH_HOLD: assert property (cs_idle |=> $stable(write_latch_flag))
    else $error("latch changed outside frame");
  AST_SO_STABLE: assert property ($rose(sck) |-> ##2 $stable(so) [*4])
    else $error("output changed during clock high");
endmodule // spi_fram_props
bind spi_fram_write_protect_control spi_fram_props i_spi_fram_props (.*);
`default_nettype wire

// >>> tb/spi_master_model.sv
// SPI mode 0 or 3 bus master model driving the controller pins.
// Assumes sck of 200 ns made from core_clk at 25 ns.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic core_clk,
  input  wire logic so,
  output var logic  cs_n,
  output var logic  sck,
  output var logic  si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Shift n bits MSb first; hold leaves the frame open
  task automatic xfer(input logic [31:0] bits, input int n, input bit hold,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge core_clk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge core_clk) sck <= 1'b0;
      si <= bits[i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      rx = {rx[6:0], so};
      repeat (3) @(posedge core_clk);
    end
    @(posedge core_clk) sck <= 1'b0;
    repeat (4) @(posedge core_clk);
    if (!hold) close();
  endtask
  // Park the clock at its idle level; high selects mode 3 on the next frame
  task automatic idle(input logic lvl);
    @(posedge core_clk) sck <= lvl;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic close();
    @(posedge core_clk) cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // spi_master_model
`default_nettype wire

// >>> tb/spi_fram_write_protect_control_tb.sv
// Testbench: opcode frames through the master model, status and gate checks.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "fram_protect_map.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module spi_fram_write_protect_control_tb;
  logic        core_clk = 0, nrst = 0, wp_n = 1, wake_busy = 0;
  logic [1:0]  nv_bp = 2'b10;
  logic [18:0] write_addr = 19'h0_0000;
  logic [7:0]  rx;
  logic [18:0] a;
  wire logic   cs_n, sck, si, so, so_oe, nv_we, awa, rd, frd, awc, wlf;
  wire logic [1:0] nv_wr;
  int          mismatches = 0, checks = 0;
  always #12.5 core_clk = ~core_clk;
  // Nonvolatile cells keep what the block stores
  always @(posedge core_clk) if (nv_we) nv_bp <= nv_wr;
  spi_master_model i_spi_master_model (.core_clk(core_clk), .so(so), .cs_n(cs_n), .sck(sck),
    .si(si));
  spi_fram_write_protect_control i_spi_fram_write_protect_control (.core_clk(core_clk),
    .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .wake_busy(wake_busy), .nv_block_protect(nv_bp), .nv_block_protect_wr(nv_wr),
    .nv_block_protect_we(nv_we), .write_addr(write_addr), .array_write_allowed(awa),
    .read_cmd(rd), .fast_read_cmd(frd), .array_write_cmd(awc), .write_latch_flag(wlf));
  task automatic cmd(input logic [31:0] b, input int n, input bit hold);
    i_spi_master_model.xfer(b, n, hold, rx);
  endtask
  // Status read; second byte is a stray latch-set that must be ignored
  task automatic sr(input logic [7:0] e);
    cmd({`OP_STATUS_READ, `OP_LATCH_SET}, 16, 0);
    `CHK("status", e, rx)
  endtask
  task automatic status_write_cmd(input logic [7:0] d, input int n);
    cmd(`OP_LATCH_SET, 8, 0);
    cmd({16'h0000, `OP_STATUS_WRITE, d} >> (8 - n), 8 + n, 0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sr(8'h48);
    wake_busy <= 1'b1;
    sr(8'h49);
    wake_busy <= 1'b0;
    cmd(`OP_LATCH_SET, 8, 0);
    sr(8'h4A);
    cmd(`OP_LATCH_RESET, 8, 0);
    sr(8'h48);
    cmd({`OP_STATUS_WRITE, 8'h8C}, 16, 0);
    sr(8'h48);
    status_write_cmd(8'hFF, 8);
    sr(8'hCC);
    `CHK("nv_wr", 2'b11, nv_wr)
    wp_n <= 1'b0;
    status_write_cmd(8'h00, 8);
    sr(8'hCC);
    wp_n <= 1'b1;
    status_write_cmd(8'h00, 5);
    sr(8'hCC);
    for (int c = 0; c < 4; c++) begin
      status_write_cmd({c[1:0], 2'b00}, 8);
      sr(8'h40 | (c[7:0] << 2));
      cmd(`OP_LATCH_SET, 8, 0);
      cmd({`OP_ARRAY_WRITE, 24'h00_0000}, 32, 1);
      `CHK("awc", 1'b1, awc)
      for (int j = 0; j < 3; j++) begin
        a = (j == 0) ? 19'h3_FFFF : (j == 1) ? 19'h5_FFFF : `QUARTER_BASE;
        write_addr <= a;
        repeat (2) @(posedge core_clk);
        `CHK("awa", !(c == 3 || (c == 2 && a >= `HALF_BASE) || (c == 1 && a >= `QUARTER_BASE)), awa)
      end
      i_spi_master_model.close();
      `CHK("latch", 1'b0, wlf)
    end
    cmd({`OP_ARRAY_WRITE, 24'h00_0000}, 32, 1);
    `CHK("awc", 1'b0, awc)
    i_spi_master_model.close();
    for (int k = 0; k < 3; k++) begin
      cmd((k == 0) ? `OP_ARRAY_READ : (k == 1) ? `OP_FAST_ARRAY_READ : 8'hA5, 8, 1);
      `CHK("rd", k == 0, rd)
      `CHK("frd", k == 1, frd)
      cmd(`OP_LATCH_SET, 8, 1);
      `CHK("so_oe", 1'b0, so_oe)
      i_spi_master_model.close();
      `CHK("latch", 1'b0, wlf)
    end
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sr(8'h4C);
    i_spi_master_model.idle(1'b1);
    sr(8'h4C);
    end_of_test();
  end
endmodule // spi_fram_write_protect_control_tb
`default_nettype wire
